// file: core/t16w_defs.svh
// Register offsets, field positions, reset values and fixed tops of the 16-bit wave timer
`ifndef T16W_DEFS_SVH
`define T16W_DEFS_SVH

// Register word indices (byte address = 4 * index)
`define T16W_IDX_CTRL_A 8'h2F
`define T16W_IDX_CTRL_B 8'h2E
`define T16W_IDX_CMP_A 8'h30
`define T16W_IDX_CMP_B 8'h31
`define T16W_IDX_CAPTURE 8'h32
`define T16W_IDX_COUNT 8'h33
`define T16W_IDX_IRQ_STATUS 8'h34
`define T16W_IDX_IRQ_MASK 8'h35
`define T16W_IDX_PORT_DIR 8'h36
`define T16W_IDX_PORT_DATA 8'h37
`define T16W_IDX_TICK_DIV 8'h38

// Control A fields
`define T16W_ACT_A_HI 7
`define T16W_ACT_A_LO 6
`define T16W_ACT_B_HI 5
`define T16W_ACT_B_LO 4
`define T16W_WAVE_LOW_HI 1
`define T16W_WAVE_LOW_LO 0
`define T16W_CTRL_A_WMASK 8'hF3
// Control B fields
`define T16W_WAVE_HIGH_HI 4
`define T16W_WAVE_HIGH_LO 3

`define T16W_RESET_8 8'h00
`define T16W_RESET_16 16'h0000

// Interrupt status bits
`define T16W_IRQ_OVF 0
`define T16W_IRQ_CMP_A 1
`define T16W_IRQ_CMP_B 2

// Count limits
`define T16W_BOTTOM 16'h0000
`define T16W_MAX 16'hFFFF
`define T16W_TOP_8BIT 16'h00FF
`define T16W_TOP_9BIT 16'h01FF
`define T16W_TOP_10BIT 16'h03FF

`endif

// file: core/t16w_pkg.sv
// Types shared by the 16-bit wave timer
`default_nettype none
package t16w_pkg;
    typedef enum logic [3:0] {
        T16W_NORMAL = 4'h0,
        T16W_PC_8 = 4'h1,
        T16W_PC_9 = 4'h2,
        T16W_PC_10 = 4'h3,
        T16W_CTC_CMPA = 4'h4,
        T16W_FAST_8 = 4'h5,
        T16W_FAST_9 = 4'h6,
        T16W_FAST_10 = 4'h7,
        T16W_PFC_CAP = 4'h8,
        T16W_PFC_CMPA = 4'h9,
        T16W_PC_CAP = 4'hA,
        T16W_PC_CMPA = 4'hB,
        T16W_CTC_CAP = 4'hC,
        T16W_RESERVED = 4'hD,
        T16W_FAST_CAP = 4'hE,
        T16W_FAST_CMPA = 4'hF
    } t16w_mode_e;

    typedef enum logic [1:0] {
        T16W_FAM_NORMAL = 2'b00,
        T16W_FAM_FAST = 2'b01,
        T16W_FAM_PHASE = 2'b10,
        T16W_FAM_PFC = 2'b11
    } t16w_family_e;

    // Counting direction of the dual-slope modes
    typedef enum logic {
        T16W_UP = 1'b0,
        T16W_DOWN = 1'b1
    } t16w_dir_e;
endpackage : t16w_pkg
`default_nettype wire

// file: core/t16w_timer.sv
// Wave-mode and compare-output logic of a 16-bit timer with an Avalon-MM slave
`include "t16w_defs.svh"
`default_nettype none

// How it works
// [RQ1] Everything runs on core_clk; the tick enable gates counting and flag updates.
// [RQ2] Double-buffered compare values load from buffer only at the mode's update point.
// [RQ3] Phase-and-frequency-correct modes load buffers at bottom; overflow flag at bottom, as in phase-correct modes.
// [RQ4] Nonzero output action hands the pin from port data to the compare output.
// [RQ5] Pin driver is enabled only while the direction bit for that pin is set.
// [RQ6] Non-PWM actions: 00 off, 01 toggle, 10 clear, 11 set on match.
// [RQ7] Fast PWM action 01: off if top bit 0, else toggle A, B reserved.
// [RQ8] Fast PWM 10 clears on match, sets at bottom; 11 inverts that.
// [RQ9] Fast PWM: compare equal to top with upper action bit set ignores match.
// [RQ10] Phase modes 10: clear on up match, set on down match; 11 reversed.
// [RQ11] Phase modes action 01: off if top bit 0, else toggle A, B reserved.
// [RQ12] Mode low bits sit at control A bits 1:0, high bits in control B.
// [RQ13] Mode selects normal, clear-on-match, fast, phase, phase-frequency; 13 reserved.
// [RQ14] Modes 0, 4, 12: tops max, compare A, capture; immediate load; overflow at max.
// [RQ15] Phase modes 1-3, 10, 11: fixed or register top; load at top; overflow at bottom.
// [RQ16] Modes 8, 9: top from capture or compare A; load and overflow at bottom.
// [RQ17] Fast modes 5-7, 14, 15: load at bottom, overflow at top.
// [RQ18] Mode high bits live at control B bits 4:3.
// [RQ19] Control A bits 3:2 read zero, ignore writes; all fields reset to zero.
module t16w_timer (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    output logic wave_out_a,
    output logic wave_out_a_oe,
    output logic wave_out_b,
    output logic wave_out_b_oe
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction : merge16

    // Next output level given action bits and a match/bottom event in a PWM family
    function automatic logic pwm_level(input logic [1:0] act, input logic cur, input logic ev_clr);
        pwm_level = (act == 2'b10) ? ~ev_clr : ((act == 2'b11) ? ev_clr : cur);
    endfunction : pwm_level

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] ctrl_a;
    logic [1:0] wave_mode_high_bits;
    logic [15:0] cmp_buf_a, cmp_buf_b, compare_value_a, compare_value_b;
    logic [15:0] capture_value, count_value, tick_div, tick_cnt;
    logic [2:0] irq_status, irq_mask;
    logic [1:0] port_dir, port_data;
    logic wave_a, wave_b, count_dir, ack;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire logic [7:0] idx = avs_address[9:2];
    wire logic wr = avs_write && ack;
    wire logic be0 = avs_byteenable[0];
    wire logic wr_ca = wr && idx == `T16W_IDX_CTRL_A && be0;
    wire logic wr_cb = wr && idx == `T16W_IDX_CTRL_B && be0;
    wire logic wr_cmpa = wr && idx == `T16W_IDX_CMP_A;
    wire logic wr_cmpb = wr && idx == `T16W_IDX_CMP_B;
    wire logic wr_cap = wr && idx == `T16W_IDX_CAPTURE;
    wire logic wr_cnt = wr && idx == `T16W_IDX_COUNT;
    wire logic wr_ist = wr && idx == `T16W_IDX_IRQ_STATUS && be0;
    wire logic wr_imk = wr && idx == `T16W_IDX_IRQ_MASK && be0;
    wire logic wr_dir = wr && idx == `T16W_IDX_PORT_DIR && be0;
    wire logic wr_dat = wr && idx == `T16W_IDX_PORT_DATA && be0;
    wire logic wr_div = wr && idx == `T16W_IDX_TICK_DIV;

    // One wait cycle, then acknowledge for one cycle
    assign avs_waitrequest = (avs_read || avs_write) && !ack;

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    wire logic [1:0] wave_mode_low_bits = ctrl_a[`T16W_WAVE_LOW_HI:`T16W_WAVE_LOW_LO];
    wire logic [3:0] wave_mode_select = {wave_mode_high_bits, wave_mode_low_bits}; // [RQ12]
    wire logic wave_mode_top_bit = wave_mode_select[3];
    wire logic [1:0] chan_a_output_action = ctrl_a[`T16W_ACT_A_HI:`T16W_ACT_A_LO];
    wire logic [1:0] chan_b_output_action = ctrl_a[`T16W_ACT_B_HI:`T16W_ACT_B_LO];
    t16w_pkg::t16w_mode_e mode;
    t16w_pkg::t16w_family_e fam;
    logic [15:0] top;
    assign mode = t16w_pkg::t16w_mode_e'(wave_mode_select);

    always_comb
    begin
        fam = t16w_pkg::T16W_FAM_NORMAL;
        top = `T16W_MAX;
        case (mode) // [RQ13]
            t16w_pkg::T16W_NORMAL: top = `T16W_MAX; // [RQ14]
            t16w_pkg::T16W_CTC_CMPA: top = compare_value_a;
            t16w_pkg::T16W_CTC_CAP: top = capture_value;
            t16w_pkg::T16W_PC_8:
            begin
                fam = t16w_pkg::T16W_FAM_PHASE; // [RQ15]
                top = `T16W_TOP_8BIT;
            end
            t16w_pkg::T16W_PC_9:
            begin
                fam = t16w_pkg::T16W_FAM_PHASE;
                top = `T16W_TOP_9BIT;
            end
            t16w_pkg::T16W_PC_10:
            begin
                fam = t16w_pkg::T16W_FAM_PHASE;
                top = `T16W_TOP_10BIT;
            end
            t16w_pkg::T16W_PC_CAP:
            begin
                fam = t16w_pkg::T16W_FAM_PHASE;
                top = capture_value;
            end
            t16w_pkg::T16W_PC_CMPA:
            begin
                fam = t16w_pkg::T16W_FAM_PHASE;
                top = compare_value_a;
            end
            t16w_pkg::T16W_FAST_8:
            begin
                fam = t16w_pkg::T16W_FAM_FAST; // [RQ17]
                top = `T16W_TOP_8BIT;
            end
            t16w_pkg::T16W_FAST_9:
            begin
                fam = t16w_pkg::T16W_FAM_FAST;
                top = `T16W_TOP_9BIT;
            end
            t16w_pkg::T16W_FAST_10:
            begin
                fam = t16w_pkg::T16W_FAM_FAST;
                top = `T16W_TOP_10BIT;
            end
            t16w_pkg::T16W_FAST_CAP:
            begin
                fam = t16w_pkg::T16W_FAM_FAST;
                top = capture_value;
            end
            t16w_pkg::T16W_FAST_CMPA:
            begin
                fam = t16w_pkg::T16W_FAM_FAST;
                top = compare_value_a;
            end
            t16w_pkg::T16W_PFC_CAP:
            begin
                fam = t16w_pkg::T16W_FAM_PFC; // [RQ16]
                top = capture_value;
            end
            t16w_pkg::T16W_PFC_CMPA:
            begin
                fam = t16w_pkg::T16W_FAM_PFC;
                top = compare_value_a;
            end
            // Reserved mode: counter holds, outputs hold
            default: top = `T16W_MAX;
        endcase
    end

    wire logic reserved = (mode == t16w_pkg::T16W_RESERVED); // [RQ13]
    wire logic dual = (fam == t16w_pkg::T16W_FAM_PHASE) || (fam == t16w_pkg::T16W_FAM_PFC);
    wire logic buffered = (fam != t16w_pkg::T16W_FAM_NORMAL);

    // ------------------------------------------------------------
    // Tick enable divider
    // ------------------------------------------------------------
    wire logic tick_wrap = (tick_cnt >= tick_div);
    wire logic timer_tick = tick_wrap && !reserved; // [RQ1]

    // ------------------------------------------------------------
    // Count sequence
    // ------------------------------------------------------------
    wire logic at_top = (count_value == top);
    wire logic at_bottom = (count_value == `T16W_BOTTOM);
    logic [15:0] next_count;
    logic next_dir;
    always_comb
    begin
        next_count = count_value + 16'h0001;
        next_dir = count_dir;
        if (dual)
        begin
            if (count_dir == t16w_pkg::T16W_DOWN)
            begin
                if (at_bottom)
                begin
                    next_dir = t16w_pkg::T16W_UP;
                    next_count = count_value + 16'h0001;
                end
                else
                    next_count = count_value - 16'h0001;
            end
            else if (at_top || count_value > top)
            begin
                next_dir = t16w_pkg::T16W_DOWN;
                next_count = count_value - 16'h0001;
            end
        end
        else if (at_top)
            next_count = `T16W_BOTTOM;
    end

    // Update point of the compare buffers and overflow point per family
    wire logic load_pt = (fam == t16w_pkg::T16W_FAM_PHASE) ? at_top : at_bottom; // [RQ2] [RQ3]
    wire logic ovf_pt = (fam == t16w_pkg::T16W_FAM_NORMAL) ? (count_value == `T16W_MAX) :
                        (fam == t16w_pkg::T16W_FAM_FAST) ? at_top :
                        (at_bottom && count_dir == t16w_pkg::T16W_DOWN); // [RQ14] [RQ15] [RQ16]
    wire logic match_a = (count_value == compare_value_a);
    wire logic match_b = (count_value == compare_value_b);
    wire logic going_down = dual && (count_dir == t16w_pkg::T16W_DOWN || at_top);

    // ------------------------------------------------------------
    // Waveform generation
    // ------------------------------------------------------------
    logic next_wave_a, next_wave_b;
    always_comb
    begin
        next_wave_a = wave_a;
        next_wave_b = wave_b;
        case (fam)
            t16w_pkg::T16W_FAM_NORMAL:
            begin
                if (match_a) // [RQ6]
                    next_wave_a = chan_a_output_action[1] ? chan_a_output_action[0] :
                                  (chan_a_output_action[0] ? ~wave_a : wave_a);
                if (match_b)
                    next_wave_b = chan_b_output_action[1] ? chan_b_output_action[0] :
                                  (chan_b_output_action[0] ? ~wave_b : wave_b);
            end
            t16w_pkg::T16W_FAM_FAST:
            begin
                // Match ignored when compare sits at top with upper action bit set; bottom still acts [RQ9]
                if (match_a && !(compare_value_a == top && chan_a_output_action[1]))
                    next_wave_a = (chan_a_output_action == 2'b01) ? ~wave_a : // [RQ7]
                                  pwm_level(chan_a_output_action, wave_a, 1'b1); // [RQ8]
                else if (at_bottom)
                    next_wave_a = pwm_level(chan_a_output_action, wave_a, 1'b0);
                if (match_b && !(compare_value_b == top && chan_b_output_action[1]))
                    next_wave_b = pwm_level(chan_b_output_action, wave_b, 1'b1);
                else if (at_bottom)
                    next_wave_b = pwm_level(chan_b_output_action, wave_b, 1'b0);
            end
            default:
            begin
                if (match_a) // [RQ10] [RQ11]
                    next_wave_a = (chan_a_output_action == 2'b01) ? ~wave_a :
                                  pwm_level(chan_a_output_action, wave_a, !going_down);
                if (match_b)
                    next_wave_b = pwm_level(chan_b_output_action, wave_b, !going_down);
            end
        endcase
    end

    // Action 01 connects only A and only with the top mode bit set in PWM families
    wire logic conn_a = buffered ? (chan_a_output_action[1] ||
                        (chan_a_output_action[0] && wave_mode_top_bit)) :
                        (chan_a_output_action != 2'b00); // [RQ4] [RQ7] [RQ11]
    wire logic conn_b = buffered ? chan_b_output_action[1] : (chan_b_output_action != 2'b00);
    assign wave_out_a = conn_a ? wave_a : port_data[0]; // [RQ4]
    assign wave_out_b = conn_b ? wave_b : port_data[1];
    assign wave_out_a_oe = port_dir[0]; // [RQ5]
    assign wave_out_b_oe = port_dir[1];

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    wire logic [2:0] irq_set = timer_tick ? {match_b, match_a, ovf_pt} : 3'b000;
    assign irq = |(irq_status & irq_mask);

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    logic [31:0] rd_mux;
    always_comb
    begin
        case (idx)
            `T16W_IDX_CTRL_A: rd_mux = {24'h00_0000, ctrl_a}; // [RQ19]
            `T16W_IDX_CTRL_B: rd_mux = {27'h000_0000, wave_mode_high_bits, 3'b000}; // [RQ18]
            `T16W_IDX_CMP_A: rd_mux = {16'h0000, cmp_buf_a};
            `T16W_IDX_CMP_B: rd_mux = {16'h0000, cmp_buf_b};
            `T16W_IDX_CAPTURE: rd_mux = {16'h0000, capture_value};
            `T16W_IDX_COUNT: rd_mux = {16'h0000, count_value};
            `T16W_IDX_IRQ_STATUS: rd_mux = {29'h0000_0000, irq_status};
            `T16W_IDX_IRQ_MASK: rd_mux = {29'h0000_0000, irq_mask};
            `T16W_IDX_PORT_DIR: rd_mux = {30'h0000_0000, port_dir};
            `T16W_IDX_PORT_DATA: rd_mux = {30'h0000_0000, port_data};
            `T16W_IDX_TICK_DIV: rd_mux = {16'h0000, tick_div};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------
    // Bus side state
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ack <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end
        else
        begin
            ack <= (avs_read || avs_write) && !ack;
            if (avs_read && !ack)
                avs_readdata <= rd_mux;
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_a <= `T16W_RESET_8; // [RQ19]
            wave_mode_high_bits <= 2'b00;
            capture_value <= `T16W_RESET_16;
            irq_mask <= 3'b000;
            port_dir <= 2'b00;
            port_data <= 2'b00;
            tick_div <= `T16W_RESET_16;
        end
        else
        begin
            if (wr_ca)
                ctrl_a <= avs_writedata[7:0] & `T16W_CTRL_A_WMASK; // [RQ19]
            if (wr_cb)
                wave_mode_high_bits <= avs_writedata[`T16W_WAVE_HIGH_HI:`T16W_WAVE_HIGH_LO];
            if (wr_cap)
                capture_value <= merge16(capture_value, avs_writedata, avs_byteenable);
            if (wr_imk)
                irq_mask <= avs_writedata[2:0];
            if (wr_dir)
                port_dir <= avs_writedata[1:0];
            if (wr_dat)
                port_data <= avs_writedata[1:0];
            if (wr_div)
                tick_div <= merge16(tick_div, avs_writedata, avs_byteenable);
        end
    end

    // ------------------------------------------------------------
    // Timer core
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            tick_cnt <= `T16W_RESET_16;
            count_value <= `T16W_RESET_16;
            count_dir <= t16w_pkg::T16W_UP;
            cmp_buf_a <= `T16W_RESET_16;
            cmp_buf_b <= `T16W_RESET_16;
            compare_value_a <= `T16W_RESET_16;
            compare_value_b <= `T16W_RESET_16;
            wave_a <= 1'b0;
            wave_b <= 1'b0;
            irq_status <= 3'b000;
        end
        else
        begin
            tick_cnt <= tick_wrap ? `T16W_RESET_16 : tick_cnt + 16'h0001;
            if (wr_cmpa)
                cmp_buf_a <= merge16(cmp_buf_a, avs_writedata, avs_byteenable);
            if (wr_cmpb)
                cmp_buf_b <= merge16(cmp_buf_b, avs_writedata, avs_byteenable);
            // Software write to the counter wins over the tick
            if (wr_cnt)
                count_value <= merge16(count_value, avs_writedata, avs_byteenable);
            else if (timer_tick) // [RQ1]
            begin
                count_value <= next_count;
                count_dir <= next_dir;
                wave_a <= next_wave_a;
                wave_b <= next_wave_b;
            end
            if (!buffered) // [RQ14]
            begin
                compare_value_a <= cmp_buf_a;
                compare_value_b <= cmp_buf_b;
            end
            else if (timer_tick && load_pt) // [RQ2] [RQ3]
            begin
                compare_value_a <= cmp_buf_a;
                compare_value_b <= cmp_buf_b;
            end
            // Set wins over a write-one clear
            irq_status <= (irq_status & ~(wr_ist ? avs_writedata[2:0] : 3'b000)) | irq_set;
        end
    end

endmodule : t16w_timer
`default_nettype wire

// file: sim/t16w_props.sv
// Port-level assertions for the wave timer
`include "t16w_defs.svh"
`default_nettype none
module t16w_props (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic irq,
    input wire logic wave_out_a,
    input wire logic wave_out_a_oe,
    input wire logic wave_out_b,
    input wire logic wave_out_b_oe
);
    // ----
    // Bus and pin relations
    // ----
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    wire logic rd_ack;
    assign rd_ack = avs_read && !avs_waitrequest;
    wait_once_a: assert property (
        $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("Bus answer not after one wait cycle");
    wait_cause_a: assert property (avs_waitrequest |-> avs_read || avs_write)
        else $error("Wait without request");
    wait_short_a: assert property (avs_waitrequest |=> !avs_waitrequest)
        else $error("Wait longer than one cycle");
    rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("Read data moved without a read");
    resv_zero_a: assert property (
        rd_ack && avs_address[9:2] == `T16W_IDX_CTRL_A |-> avs_readdata[3:2] == 2'b00)
        else $error("Reserved control bits read nonzero");
    unmap_zero_a: assert property (
        rd_ack && avs_address[9:2] > `T16W_IDX_TICK_DIV |-> avs_readdata == 32'h0000_0000)
        else $error("Unmapped read nonzero");
    oe_by_write_a: assert property (
        $changed({wave_out_a_oe, wave_out_b_oe}) |-> $past(avs_write))
        else $error("Pin enable changed without a write");
    boot_quiet_a: assert property (
        $rose(nrst) |-> !irq && !wave_out_a_oe && !wave_out_b_oe)
        else $error("Outputs active after reset");
    irq_fall_a: assert property ($fell(irq) |-> $past(avs_write))
        else $error("Interrupt dropped without a write");
    cover property (rd_ack);
    cover property ($rose(irq));
    cover property ($rose(wave_out_a) ##[1:300] $fell(wave_out_a));
endmodule : t16w_props
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench for the wave timer
`include "t16w_defs.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [3:0] m; logic [1:0] act; logic [15:0] cmp, cap;
        logic [7:0] div; int hi, per;} t16w_row_s;
    logic core_clk, nrst, avs_read, avs_write, avs_waitrequest, irq;
    logic wave_out_a, wave_out_a_oe, wave_out_b, wave_out_b_oe;
    logic [9:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd, keep;
    logic [3:0] avs_byteenable;
    int err_total, cmp_count, hi, per;
    t16w_row_s rows[12] = '{
        '{4'h5, 2'd2, 16'h003F, 16'h0, 8'h0, 63, 256},
        '{4'h5, 2'd3, 16'h003F, 16'h0, 8'h0, 193, 256},
        '{4'h6, 2'd2, 16'h003F, 16'h0, 8'h0, 63, 512},
        '{4'h2, 2'd2, 16'h0040, 16'h0, 8'h0, 128, 1022},
        '{4'hA, 2'd2, 16'h0020, 16'h0080, 8'h0, 64, 256},
        '{4'h8, 2'd2, 16'h0020, 16'h0080, 8'h0, 64, 256},
        '{4'h9, 2'd1, 16'h0040, 16'h0, 8'h0, 128, 256},
        '{4'hB, 2'd1, 16'h0080, 16'h0, 8'h0, 256, 512},
        '{4'hF, 2'd1, 16'h007F, 16'h0, 8'h0, 128, 256},
        '{4'h4, 2'd1, 16'h003F, 16'h0, 8'h0, 64, 128},
        '{4'hC, 2'd1, 16'h0, 16'h001F, 8'h0, 32, 64},
        '{4'h5, 2'd2, 16'h003F, 16'h0, 8'h1, 126, 512}};
    t16w_timer t16w_timer_inst (.core_clk(core_clk), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq), .wave_out_a(wave_out_a),
        .wave_out_a_oe(wave_out_a_oe), .wave_out_b(wave_out_b), .wave_out_b_oe(wave_out_b_oe));
    // ----
    // Tasks
    // ----
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic final_report;
        $display("Counts: %0d mismatches, %0d compares", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report
    // Waitrequest taken at the edge before its update; return lets outputs settle
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] d);
        @(posedge core_clk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge core_clk iff avs_waitrequest === 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(negedge core_clk);
    endtask : bus
    // Passing through normal mode first loads every compare value at once
    task automatic setup(input t16w_row_s r);
        bus(1, `T16W_IDX_CTRL_B, 32'h0);
        bus(1, `T16W_IDX_CTRL_A, 32'h0);
        bus(1, `T16W_IDX_TICK_DIV, 32'(r.div));
        bus(1, `T16W_IDX_CAPTURE, 32'(r.cap));
        bus(1, `T16W_IDX_CMP_A, 32'(r.cmp));
        bus(1, `T16W_IDX_CTRL_B, 32'({r.m[3:2], 3'b000}));
        bus(1, `T16W_IDX_CTRL_A, 32'({r.act, 4'h0, r.m[1:0]}));
        bus(1, `T16W_IDX_COUNT, 32'h0);
    endtask : setup
    // First full period after the second rising edge is measured
    task automatic measure(output int h, output int p);
        int rises;
        logic prev;
        h = 0;
        p = 0;
        rises = 0;
        prev = wave_out_a;
        for (int i = 0; i < 6000 && rises < 3; i++)
        begin
            @(negedge core_clk);
            if (wave_out_a === 1'b1 && prev === 1'b0)
                rises++;
            prev = wave_out_a;
            if (rises == 2)
                p++;
            if (rises == 2 && wave_out_a === 1'b1)
                h++;
        end
    endtask : measure
    // ----
    // Tests
    // ----
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    initial
    begin
        #2400000;
        err_total++;
        final_report();
    end
    initial
    begin
        nrst = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 10'h0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        repeat (20) @(posedge core_clk);
        nrst <= 1'b1;
        bus(0, `T16W_IDX_CTRL_A, 32'h0);
        chk("ctrl_a reset", 32'h0, rd);
        bus(1, `T16W_IDX_CTRL_A, 32'h0000_00FF);
        bus(0, `T16W_IDX_CTRL_A, 32'h0);
        chk("ctrl_a", 32'h0000_00F3, rd);
        bus(1, `T16W_IDX_CTRL_B, 32'h0000_00FF);
        bus(0, `T16W_IDX_CTRL_B, 32'h0);
        chk("ctrl_b", 32'h0000_0018, rd);
        bus(0, 8'h3F, 32'h0);
        chk("unmapped", 32'h0, rd);
        bus(1, `T16W_IDX_CTRL_A, 32'h0);
        bus(1, `T16W_IDX_CTRL_B, 32'h0);
        bus(1, `T16W_IDX_PORT_DATA, 32'h1);
        chk("pins off", 32'h2, {wave_out_a_oe, wave_out_b_oe, wave_out_a, wave_out_b});
        bus(1, `T16W_IDX_PORT_DIR, 32'h3);
        chk("pins on", 32'hE, {wave_out_a_oe, wave_out_b_oe, wave_out_a, wave_out_b});
        bus(1, `T16W_IDX_CMP_B, 32'h10);
        for (int k = 3; k > 0; k--)
        begin
            bus(1, `T16W_IDX_CTRL_A, 32'(k << 4));
            bus(1, `T16W_IDX_COUNT, 32'h0);
            repeat (40) @(posedge core_clk);
            chk("normal b", 32'(k != 2), 32'(wave_out_b));
        end
        foreach (rows[i])
        begin
            setup(rows[i]);
            measure(hi, per);
            chk("high", rows[i].hi, hi);
            chk("period", rows[i].per, per);
        end
        setup('{4'hE, 2'd2, 16'h0040, 16'h0040, 8'h0, 0, 0});
        hi = 0;
        for (int i = 0; i < 300; i++)
        begin
            @(negedge core_clk);
            if (wave_out_a === 1'b1)
                hi++;
        end
        chk("top match", 300, hi);
        bus(1, `T16W_IDX_IRQ_MASK, 32'h0);
        bus(0, `T16W_IDX_IRQ_STATUS, 32'h0);
        chk("ovf flag", 32'h1, 32'(rd[0]));
        chk("irq masked", 32'h0, 32'(irq));
        bus(1, `T16W_IDX_IRQ_MASK, 32'h1);
        chk("irq on", 32'h1, 32'(irq));
        bus(1, `T16W_IDX_CTRL_B, 32'h0000_0018);
        bus(1, `T16W_IDX_CTRL_A, 32'h1);
        bus(1, `T16W_IDX_IRQ_STATUS, 32'h7);
        bus(0, `T16W_IDX_IRQ_STATUS, 32'h0);
        chk("status clear", 32'h0, rd);
        chk("irq off", 32'h0, 32'(irq));
        bus(0, `T16W_IDX_COUNT, 32'h0);
        keep = rd;
        repeat (20) @(posedge core_clk);
        bus(0, `T16W_IDX_COUNT, 32'h0);
        chk("count hold", keep, rd);
        final_report();
    end
endmodule : tb_top
bind t16w_timer t16w_props t16w_props_inst (.core_clk(core_clk), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .wave_out_a(wave_out_a), .wave_out_a_oe(wave_out_a_oe), .wave_out_b(wave_out_b),
    .wave_out_b_oe(wave_out_b_oe));
`default_nettype wire
